/* File: core/serial_port_pkg.sv */
package serial_port_pkg;

	// ----------------------------------------
	// frame layout
	// ----------------------------------------
	localparam int FRAME_BITS = 32;
	localparam int HEADER_BITS = 12;
	localparam int ADDR_BITS = 4;
	localparam int DATA_BITS = 16;
	localparam int COUNT_BITS = 5;
	localparam logic [COUNT_BITS-1:0] LAST_BIT = 5'h1f;
	localparam logic [COUNT_BITS-1:0] FIRST_BIT = 5'h00;
	localparam logic [HEADER_BITS-1:0] FRAME_HEADER = 12'h001;

	typedef struct packed {
		logic [HEADER_BITS-1:0] header;
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} frame_t;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} frame_word_t;

	// ----------------------------------------
	// register addresses and bank indices
	// ----------------------------------------
	localparam int REG_COUNT = 9;
	localparam logic [ADDR_BITS-1:0] ADDR_CAL = 4'h0;
	localparam logic [ADDR_BITS-1:0] ADDR_CONFIG = 4'h1;
	localparam logic [ADDR_BITS-1:0] ADDR_I_OFFSET = 4'h2;
	localparam logic [ADDR_BITS-1:0] ADDR_I_RANGE = 4'h3;
	localparam logic [ADDR_BITS-1:0] ADDR_EXT = 4'h9;
	localparam logic [ADDR_BITS-1:0] ADDR_Q_OFFSET = 4'ha;
	localparam logic [ADDR_BITS-1:0] ADDR_Q_RANGE = 4'hb;
	localparam logic [ADDR_BITS-1:0] ADDR_PHASE_FINE = 4'he;
	localparam logic [ADDR_BITS-1:0] ADDR_PHASE_COARSE = 4'hf;

	localparam logic [3:0] IDX_CAL = 4'h0;
	localparam logic [3:0] IDX_NONE = 4'hf;
	localparam int CAL_START_BIT = 15;

	// first field sits at the top of the bank, so bank index 8 maps to it
	typedef struct packed {
		logic [DATA_BITS-1:0] sample_phase_coarse;
		logic [DATA_BITS-1:0] sample_phase_fine;
		logic [DATA_BITS-1:0] second_channel_range_trim;
		logic [DATA_BITS-1:0] second_channel_offset_trim;
		logic [DATA_BITS-1:0] extended_settings;
		logic [DATA_BITS-1:0] first_channel_range_trim;
		logic [DATA_BITS-1:0] first_channel_offset_trim;
		logic [DATA_BITS-1:0] output_configuration;
		logic [DATA_BITS-1:0] calibration_trigger;
	} ctrl_regs_t;

	typedef logic [REG_COUNT-1:0][DATA_BITS-1:0] reg_bank_t;

	// ----------------------------------------
	// power-on defaults
	// ----------------------------------------
	localparam logic [DATA_BITS-1:0] DEF_CAL = 16'h7fff;
	localparam logic [DATA_BITS-1:0] DEF_CONFIG = 16'hb2ff;
	localparam logic [DATA_BITS-1:0] DEF_TRIM = 16'h0000;
	localparam logic [DATA_BITS-1:0] DEF_EXT = 16'h0000;
	localparam logic [DATA_BITS-1:0] DEF_PHASE = 16'h0000;
	localparam reg_bank_t REG_DEFAULT = {DEF_PHASE, DEF_PHASE, DEF_TRIM, DEF_TRIM,
		DEF_EXT, DEF_TRIM, DEF_TRIM, DEF_CONFIG, DEF_CAL};

	// address to bank index; reserved codes give IDX_NONE
	function automatic logic [3:0] reg_index(input logic [ADDR_BITS-1:0] addr);
		logic [3:0] idx;
		idx = IDX_NONE;
		unique case (addr)
			ADDR_CAL: idx = 4'h0;
			ADDR_CONFIG: idx = 4'h1;
			ADDR_I_OFFSET: idx = 4'h2;
			ADDR_I_RANGE: idx = 4'h3;
			ADDR_EXT: idx = 4'h4;
			ADDR_Q_OFFSET: idx = 4'h5;
			ADDR_Q_RANGE: idx = 4'h6;
			ADDR_PHASE_FINE: idx = 4'h7;
			ADDR_PHASE_COARSE: idx = 4'h8;
			default: idx = IDX_NONE;
		endcase
		return idx;
	endfunction

endpackage

/* File: core/serial_frame_receiver.sv */
`timescale 1ns/1ps
module serial_frame_receiver (
	// link pins
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic serial_write_line,
	// from the system clock side
	input wire logic link_clear,
	// completed frame
	output logic frame_toggle,
	output serial_port_pkg::frame_word_t frame_word
);
	import serial_port_pkg::*;

	logic [COUNT_BITS-1:0] bit_count;
	logic [FRAME_BITS-2:0] shift;
	frame_t next_frame;
	logic frame_done;

	assign next_frame = frame_t'({shift, serial_write_line});
	assign frame_done = (bit_count == LAST_BIT) && (next_frame.header == FRAME_HEADER);

	// ----------------------------------------
	// shift and count
	// ----------------------------------------
	// select high clears without needing an edge, so a cut frame is dropped
	// even when the clock stops right after it
	always_ff @(posedge sclk or posedge serial_select_n or posedge link_clear) begin
		if (serial_select_n || link_clear) begin
			bit_count <= FIRST_BIT;
			shift <= '0;
		end else begin
			shift <= next_frame[FRAME_BITS-2:0]; // R4 R6
			bit_count <= bit_count + 5'h01; // R10
		end
	end

	// ----------------------------------------
	// completed frame, held for the other domain
	// ----------------------------------------
	// word stays put for a whole frame, far longer than the two-stage sync
	always_ff @(posedge sclk or posedge link_clear) begin
		if (link_clear) begin
			frame_toggle <= 1'b0;
			frame_word <= '0;
		end else if (!serial_select_n && frame_done) begin // R7 R18
			frame_toggle <= ~frame_toggle;
			frame_word <= '{addr: next_frame.addr, data: next_frame.data}; // R8 R9
		end
	end

	// ----------------------------------------
	// checks on the link clock
	// ----------------------------------------
	property p_count_wrap;
		@(posedge sclk) disable iff (link_clear || serial_select_n)
		bit_count == LAST_BIT |=> bit_count == FIRST_BIT;
	endproperty
	a_count_wrap: assert property (p_count_wrap) else $error("frame count did not wrap"); // R10

	property p_bad_header_dropped;
		@(posedge sclk) disable iff (link_clear || serial_select_n)
		(bit_count == LAST_BIT && next_frame.header != FRAME_HEADER) |=> $stable(frame_toggle);
	endproperty
	a_bad_header_dropped: assert property (p_bad_header_dropped) else $error("bad header taken"); // R19

	property p_good_frame_taken;
		@(posedge sclk) disable iff (link_clear || serial_select_n)
		frame_done |=> frame_toggle != $past(frame_toggle) && frame_word.addr == $past(next_frame.addr);
	endproperty
	a_good_frame_taken: assert property (p_good_frame_taken) else $error("good frame lost"); // R7

	property p_mid_frame_quiet;
		@(posedge sclk) disable iff (link_clear || serial_select_n)
		bit_count != LAST_BIT |=> $stable(frame_toggle);
	endproperty
	a_mid_frame_quiet: assert property (p_mid_frame_quiet) else $error("early commit"); // R18

endmodule

/* File: core/serial_register_write_port.sv */
`timescale 1ns/1ps
// Notes on behaviour
// R1 - host writes all nine registers on first use, then singly.
// R2 - serial accesses accepted only in extended control mode.
// R3 - host holds select low for the whole frame.
// R4 - data line sampled on each rising serial clock edge while selected.
// R5 - receiver works at any clock rate, down to a stopped clock.
// R6 - frames are 32 bits, most significant bit first.
// R7 - frame opens with eleven zeros then a one.
// R8 - four address bits follow the header, top bit first.
// R9 - last sixteen bits are stored into the addressed register.
// R10 - 33rd edge with select low starts the next frame.
// R11 - host may leave select low permanently; framing still holds.
// R12 - register contents survive power-down and return from it.
// R13 - host sends nothing while calibration runs.
// R14 - address map: 0,1,2,3,9,a,b,e,f used; rest reserved.
// R15 - registers write-only; no effect in normal control mode.
// R16 - reset loads every register with its default.
// R17 - writing one to calibration bit 15 starts a calibration.
// R18 - commit only after 32nd edge of a good frame.
// R19 - reserved addresses and bad headers change nothing.
module serial_register_write_port (
	// system
	input wire logic clk,
	input wire logic rst_n,
	// serial link
	input wire logic sclk,
	input wire logic serial_select_n,
	input wire logic serial_write_line,
	// mode pin
	input wire logic extended_mode_sel,
	// converter controls
	output serial_port_pkg::ctrl_regs_t ctrl_out,
	output logic ext_active,
	output logic cal_start,
	output logic reg_written,
	output logic init_done
);
	import serial_port_pkg::*;

	// ----------------------------------------
	// link side
	// ----------------------------------------
	logic link_clear;
	logic frame_toggle;
	frame_word_t frame_word;

	// link logic is held clear for as long as the system reset lasts
	always_ff @(posedge clk) begin
		link_clear <= ~rst_n;
	end

	serial_frame_receiver receiver (
		.sclk(sclk),
		.serial_select_n(serial_select_n),
		.serial_write_line(serial_write_line),
		.link_clear(link_clear),
		.frame_toggle(frame_toggle),
		.frame_word(frame_word)
	); // R5 R11

	// ----------------------------------------
	// crossings
	// ----------------------------------------
	logic tog_meta;
	logic tog_sync;
	logic tog_prev;
	logic ext_meta;
	logic ext_sync;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tog_meta <= 1'b0;
			tog_sync <= 1'b0;
			tog_prev <= 1'b0;
		end else begin
			tog_meta <= frame_toggle;
			tog_sync <= tog_meta;
			tog_prev <= tog_sync;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_meta <= 1'b0;
			ext_sync <= 1'b0;
		end else begin
			ext_meta <= extended_mode_sel;
			ext_sync <= ext_meta;
		end
	end

	// ----------------------------------------
	// decode
	// ----------------------------------------
	logic commit;
	logic accept;
	logic [3:0] idx;
	logic idx_valid;

	assign commit = tog_sync ^ tog_prev;
	// frames arriving in normal mode are dropped, not queued
	assign accept = commit && ext_sync; // R2
	assign idx = reg_index(frame_word.addr); // R14
	assign idx_valid = (idx != IDX_NONE); // R19

	// ----------------------------------------
	// register bank
	// ----------------------------------------
	reg_bank_t regs;

	// nothing but reset and an accepted write touches the bank,
	// so power-down upstream leaves it intact
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			regs <= REG_DEFAULT; // R16
		end else if (accept && idx_valid) begin
			regs[idx] <= frame_word.data; // R9 R12
		end
	end

	// ----------------------------------------
	// calibration trigger
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cal_start <= 1'b0;
		end else begin
			cal_start <= accept && (idx == IDX_CAL) && frame_word.data[CAL_START_BIT]; // R17
		end
	end

	// ----------------------------------------
	// write tracking
	// ----------------------------------------
	logic [REG_COUNT-1:0] written;
	logic [REG_COUNT-1:0] next_written;

	always_comb begin
		next_written = written;
		if (accept && idx_valid) begin
			next_written[idx] = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			written <= '0;
			reg_written <= 1'b0;
		end else begin
			written <= next_written;
			reg_written <= accept && idx_valid;
		end
	end

	// only a hint to the converter; partial setups are not blocked
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			init_done <= 1'b0;
		end else begin
			init_done <= &next_written; // R1
		end
	end

	// ----------------------------------------
	// outputs to the converter
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ext_active <= 1'b0;
			ctrl_out <= ctrl_regs_t'(REG_DEFAULT);
		end else begin
			ext_active <= ext_sync;
			// normal mode shows defaults; stored values come back on return
			ctrl_out <= ext_sync ? ctrl_regs_t'(regs) : ctrl_regs_t'(REG_DEFAULT); // R15
		end
	end

	// ----------------------------------------
	// checks on the system clock
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_good_write;
		accept && idx_valid;
	endsequence

	sequence s_cal_write;
		accept && idx == IDX_CAL && frame_word.data[CAL_START_BIT];
	endsequence

	property p_write_lands;
		logic [3:0] i;
		logic [DATA_BITS-1:0] d;
		(s_good_write, i = idx, d = frame_word.data) |=> regs[i] == d;
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored"); // R9

	property p_normal_mode_frozen;
		!ext_sync |=> $stable(regs);
	endproperty
	a_normal_mode_frozen: assert property (p_normal_mode_frozen) else $error("normal mode write"); // R2

	property p_reserved_ignored;
		commit && !idx_valid |=> $stable(regs);
	endproperty
	a_reserved_ignored: assert property (p_reserved_ignored) else $error("reserved write"); // R19

	property p_preserved;
		!commit |=> $stable(regs);
	endproperty
	a_preserved: assert property (p_preserved) else $error("register lost"); // R12

	property p_cal_pulse;
		s_cal_write |=> cal_start ##1 !cal_start;
	endproperty
	a_cal_pulse: assert property (p_cal_pulse) else $error("calibration not started"); // R17

	property p_cal_cause;
		cal_start |-> $past(accept) && $past(idx) == IDX_CAL;
	endproperty
	a_cal_cause: assert property (p_cal_cause) else $error("spurious calibration"); // R17

	property p_normal_defaults;
		!ext_active |-> ctrl_out == ctrl_regs_t'(REG_DEFAULT);
	endproperty
	a_normal_defaults: assert property (p_normal_defaults) else $error("regs leak in normal"); // R15

	property p_ext_shows_regs;
		ext_sync |=> ctrl_out == ctrl_regs_t'($past(regs));
	endproperty
	a_ext_shows_regs: assert property (p_ext_shows_regs) else $error("regs not applied"); // R15

	property p_reset_defaults;
		@(posedge clk) disable iff (1'b0)
		!rst_n |=> regs == REG_DEFAULT && !cal_start && !init_done;
	endproperty
	a_reset_defaults: assert property (p_reset_defaults) else $error("bad reset state"); // R16

	property p_commit_spacing;
		commit |=> !commit [*2];
	endproperty
	a_commit_spacing: assert property (p_commit_spacing) else $error("commits too close"); // R18

	// ----------------------------------------
	// checks on pulses and write tracking
	// ----------------------------------------
	sequence s_normal_commit;
		commit && !ext_sync;
	endsequence

	sequence s_reserved_commit;
		commit && ext_sync && !idx_valid;
	endsequence

	sequence s_cal_no_start;
		accept && idx == IDX_CAL && !frame_word.data[CAL_START_BIT];
	endsequence

	property p_write_pulse;
		s_good_write |=> reg_written ##1 !reg_written;
	endproperty
	a_write_pulse: assert property (p_write_pulse) else $error("write pulse missing"); // R9

	property p_write_pulse_cause;
		reg_written |-> $past(accept) && $past(idx_valid);
	endproperty
	a_write_pulse_cause: assert property (p_write_pulse_cause) else $error("stray pulse"); // R19

	property p_normal_no_pulse;
		s_normal_commit |=> !reg_written && !cal_start;
	endproperty
	a_normal_no_pulse: assert property (p_normal_no_pulse) else $error("pulse in normal"); // R2

	property p_normal_untracked;
		s_normal_commit |=> $stable(written);
	endproperty
	a_normal_untracked: assert property (p_normal_untracked) else $error("normal tracked"); // R2

	property p_reserved_no_pulse;
		s_reserved_commit |=> !reg_written && !cal_start;
	endproperty
	a_reserved_no_pulse: assert property (p_reserved_no_pulse) else $error("reserved pulse"); // R19

	property p_idle_quiet;
		!commit |=> !reg_written && !cal_start;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("pulse without frame"); // R18

	property p_cal_needs_bit;
		cal_start |-> $past(frame_word.data[CAL_START_BIT]);
	endproperty
	a_cal_needs_bit: assert property (p_cal_needs_bit) else $error("cal without bit 15"); // R17

	property p_cal_held_off;
		s_cal_no_start |=> !cal_start;
	endproperty
	a_cal_held_off: assert property (p_cal_held_off) else $error("cal from bit 15 low"); // R17

	property p_cal_single;
		cal_start |=> !cal_start;
	endproperty
	a_cal_single: assert property (p_cal_single) else $error("cal pulse too long"); // R17

	property p_written_sets;
		logic [3:0] i;
		(s_good_write, i = idx) |=> written[i];
	endproperty
	a_written_sets: assert property (p_written_sets) else $error("write not tracked"); // R1

	property p_written_stable;
		!(accept && idx_valid) |=> $stable(written);
	endproperty
	a_written_stable: assert property (p_written_stable) else $error("tracking changed"); // R19

	property p_init_sticky;
		init_done |=> init_done;
	endproperty
	a_init_sticky: assert property (p_init_sticky) else $error("init flag dropped"); // R1

	property p_init_with_write;
		$rose(init_done) |-> reg_written;
	endproperty
	a_init_with_write: assert property (p_init_with_write) else $error("init flag early"); // R1

	// pin must stand three edges: two sync flops, then the output flop
	property p_mode_on;
		extended_mode_sel [*3] |=> ext_active;
	endproperty
	a_mode_on: assert property (p_mode_on) else $error("extended mode not seen"); // R2

	property p_mode_off;
		(!extended_mode_sel) [*3] |=> !ext_active && ctrl_out == ctrl_regs_t'(REG_DEFAULT);
	endproperty
	a_mode_off: assert property (p_mode_off) else $error("normal mode not seen"); // R15

	property p_link_held_clear;
		@(posedge clk) disable iff (1'b0)
		!rst_n |=> link_clear && !reg_written && !ext_active;
	endproperty
	a_link_held_clear: assert property (p_link_held_clear) else $error("link not cleared"); // R16

endmodule

/* File: verification/serial_host_model.sv */
`timescale 1ns/1ps
module serial_host_model (
	// serial link
	output logic sclk,
	output logic serial_select_n,
	output logic serial_write_line
);
	initial begin
		sclk = 1'b0;
		serial_select_n = 1'b1;
		serial_write_line = 1'b1;
	end

	// ----------------------------------------
	// frame sender, 32 ns serial clock
	// ----------------------------------------
	// clock idles low between frames; nbits below 32 models a cut frame
	task automatic send(input logic [31:0] word, input int nbits, input bit hold);
		int i;
		serial_select_n = 1'b0;
		for (i = 31; i > 31 - nbits; i--) begin
			serial_write_line = word[i];
			#16 sclk = 1'b1;
			#16 sclk = 1'b0;
		end
		// hold keeps select low so the next frame starts at edge 33
		if (!hold) begin
			#8 serial_select_n = 1'b1;
			// released line must not look like a held last bit
			serial_write_line = ~serial_write_line;
		end
	endtask
endmodule

/* File: verification/serial_register_write_port_tb_top.sv */
`timescale 1ns/1ps
module serial_register_write_port_tb_top;
	import serial_port_pkg::*;

	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic extended_mode_sel = 1'b0;
	wire sclk;
	wire serial_select_n;
	wire serial_write_line;
	ctrl_regs_t ctrl_out;
	logic ext_active;
	logic cal_start;
	logic reg_written;
	logic init_done;
	int fails = 0;
	int total_checks = 0;
	int n_wr = 0;
	int n_cal = 0;
	int w;
	int c;
	reg_bank_t exp_bank;
	logic [3:0] addr_tab [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'ha, 4'hb, 4'he, 4'hf};
	logic [3:0] rsv_tab [7] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'hc, 4'hd};

	always #25 clk = ~clk;

	always @(posedge clk) begin
		if (reg_written === 1'b1) n_wr++;
		if (cal_start === 1'b1) n_cal++;
	end

	serial_register_write_port dut (
		.clk(clk),
		.rst_n(rst_n),
		.sclk(sclk),
		.serial_select_n(serial_select_n),
		.serial_write_line(serial_write_line),
		.extended_mode_sel(extended_mode_sel),
		.ctrl_out(ctrl_out),
		.ext_active(ext_active),
		.cal_start(cal_start),
		.reg_written(reg_written),
		.init_done(init_done)
	);

	serial_host_model host (
		.sclk(sclk),
		.serial_select_n(serial_select_n),
		.serial_write_line(serial_write_line)
	);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [143:0] seen, input logic [143:0] exp, input string what);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t %s", $time, what);
		end
	endtask

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask

	// pin passes two sync flops, so allow a few edges
	task automatic set_mode(input logic m);
		@(posedge clk);
		#2 extended_mode_sel = m;
		wait_clk(6);
	endtask

	task automatic write(input logic [3:0] a, input logic [15:0] d, input bit hold);
		host.send({FRAME_HEADER, a, d}, 32, hold);
		if (!hold) wait_clk(8);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset;
		check(ctrl_out, REG_DEFAULT, "reset bank");
		check(ext_active, 1'b0, "reset mode flag");
		check(init_done, 1'b0, "reset init flag");
		$display("test reset done");
	endtask

	task automatic t_normal_mode;
		w = n_wr;
		write(ADDR_CONFIG, 16'h1234, 0);
		check(n_wr - w, 0, "write taken in normal mode");
		check(ctrl_out, REG_DEFAULT, "normal mode bank");
		$display("test normal mode done");
	endtask

	task automatic t_full_init;
		logic [15:0] d;
		set_mode(1'b1);
		check(ext_active, 1'b1, "extended flag");
		w = n_wr;
		c = n_cal;
		// select held low across all nine frames
		for (int i = 0; i < 9; i++) begin
			d = (i == 0) ? 16'h7fff : {i[3:0], 12'ha5c};
			exp_bank[i] = d;
			write(addr_tab[i], d, i < 8);
		end
		check(ctrl_out, exp_bank, "bank after init");
		check(n_wr - w, 9, "write pulses");
		check(n_cal - c, 0, "cal pulse without bit 15");
		check(init_done, 1'b1, "init flag");
		$display("test full init done");
	endtask

	task automatic t_calibrate;
		c = n_cal;
		write(ADDR_CAL, 16'hffff, 0);
		exp_bank[0] = 16'hffff;
		wait_clk(20);
		check(n_cal - c, 1, "cal pulse");
		check(ctrl_out, exp_bank, "bank after cal");
		$display("test calibrate done");
	endtask

	task automatic t_refused;
		w = n_wr;
		foreach (rsv_tab[i]) write(rsv_tab[i], 16'hdead, 0);
		// select stays low over a stopped clock, so the cut frame follows at edge 33
		host.send({12'h003, ADDR_CONFIG, 16'h0bad}, 32, 1);
		wait_clk(8);
		// one bit short of a frame
		host.send({FRAME_HEADER, ADDR_I_OFFSET, 16'h0bad}, 31, 0);
		wait_clk(8);
		write(ADDR_I_RANGE, 16'h4321, 0);
		exp_bank[3] = 16'h4321;
		check(n_wr - w, 1, "refused frame counted");
		check(ctrl_out, exp_bank, "bank after refusals");
		$display("test refused done");
	endtask

	task automatic t_mode_trip;
		set_mode(1'b0);
		check(ext_active, 1'b0, "mode flag low");
		check(ctrl_out, REG_DEFAULT, "normal mode output");
		set_mode(1'b1);
		check(ctrl_out, exp_bank, "bank kept");
		$display("test mode trip done");
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		exp_bank = REG_DEFAULT;
		repeat (10) @(posedge clk);
		#2 rst_n = 1'b1;
		wait_clk(3);
		t_reset();
		t_normal_mode();
		t_full_init();
		t_calibrate();
		t_refused();
		t_mode_trip();
		print_verdict();
	end

	initial begin
		#3000000;
		fails++;
		$display("[FAIL] %0t run timeout", $time);
		print_verdict();
	end
endmodule
